// ==== rtl/mcs_map.svh ====
// Register map, field positions, reset values and timing counts of the
// matchcode sequencer. Assumes an APB master on the same 10 MHz clock.
//
// Behaviour
// - The step interval is settable from 1 to 32768, resets to 1, and is the amount added or taken off.
// - The master value wraps like a fixed-digit counter: 000-3 gives 997 and 999+3 gives 002.
// - In sequence mode the master moves by the step when a decoded value equals it, and on a no-read or mismatch when their own enables are on.
// - With match replacement on (reset off) and matching active, a match emits the match string.
// - With mismatch replacement on (reset off) and matching active, a mismatch emits the mismatch string.
// - Each replacement string holds up to 64 characters, defaulting to MATCH and MISMATCH.
// - The new-master input acts only while matching and its own enable (reset off) are both on.
// - After a valid new-master request the next good read is loaded as master entry 1.
// - The load status reads the index of the next entry to load, 0 meaning idle.
// - With one master, a trigger command or new-master input sets status 1; loading clears it.
// - Direction 0 increments (default) and 1 decrements the master by the step.
// - With sequence-on-no-read on (default) a no-read advances the master too.
`ifndef MCS_MAP_SVH
`define MCS_MAP_SVH

`define MCS_ADDR_W       12
`define MCS_OFF_CTRL     12'h000
`define MCS_OFF_STEP     12'h004
`define MCS_OFF_MASTER   12'h008
`define MCS_OFF_DIGITS   12'h00C
`define MCS_OFF_CMD      12'h010
`define MCS_OFF_LOADST   12'h014
`define MCS_OFF_MLEN     12'h018
`define MCS_OFF_MMLEN    12'h01C
`define MCS_PAGE_MSTR    4'h1
`define MCS_PAGE_MMSTR   4'h2

`define MCS_CTRL_MATCH_EN   0
`define MCS_CTRL_SEQ_MODE   1
`define MCS_CTRL_DIR        2
`define MCS_CTRL_SEQ_NOREAD 3
`define MCS_CTRL_SEQ_MISM   4
`define MCS_CTRL_MASTER_LOAD_STATUS_QUERY_EN    5
`define MCS_CTRL_MREPL_EN   6
`define MCS_CTRL_MMREPL_EN  7
`define MCS_CTRL_W          8
`define MCS_CTRL_RST        8'h08
`define MCS_CMD_TRIGGER     0

`define MCS_STEP_MIN     16'h0001
`define MCS_STEP_MAX     16'h8000
`define MCS_STEP_RST     16'h0001
`define MCS_DIGITS_MIN   4'h1
`define MCS_DIGITS_MAX   4'h9
`define MCS_DIGITS_RST   4'h3
`define MCS_STR_DEPTH    64
`define MCS_MSTR_TXT     40'h4D41544348
`define MCS_MSTR_LEN     7'h05
`define MCS_MMSTR_TXT    64'h4D49534D41544348
`define MCS_MMSTR_LEN    7'h08

`define MCS_CLK_HZ       10000000
`define MCS_MASTER_LOAD_STATUS_QUERY_MS      10
`define MCS_MASTER_LOAD_STATUS_QUERY_CYCLES  ((`MCS_MASTER_LOAD_STATUS_QUERY_MS * `MCS_CLK_HZ) / 1000)

`endif

// ==== rtl/mcs_pkg.sv ====
// Types shared by the matchcode sequencer and its surroundings.
// Assumes the map header supplies all numeric constants.
package mcs_pkg;

  typedef enum {
    MCS_ST_IDLE,
    MCS_ST_EMIT
  } mcs_state_type;

  typedef enum logic [1:0] {
    MCS_RES_MATCH,
    MCS_RES_MISMATCH,
    MCS_RES_NOREAD,
    MCS_RES_LOADED
  } mcs_kind_type;

  typedef struct packed {
    logic        good;
    logic        numeric;
    logic [29:0] value;
  } mcs_read_type;

  typedef struct packed {
    mcs_kind_type kind;
    logic         replaced;
  } mcs_result_type;

  typedef struct packed {
    logic [7:0] code;
    logic       last;
  } mcs_char_type;

endpackage

// ==== rtl/mcs_sequencer.sv ====
// Matchcode sequencer: master value, stepping, replacement strings and
// new-master loading, with an APB register slave.
// Assumes decode results and APB come from logic on i_clk; the new-master
// pin is asynchronous.
//
// Local design decisions: the address map and register access over APB.
`timescale 1ns/1ps
`include "mcs_map.svh"

module mcs_sequencer
  import mcs_pkg::*;
#(
  parameter int VAL_W       = 30,
  parameter int MASTER_LOAD_STATUS_QUERY_CYCLES = `MCS_MASTER_LOAD_STATUS_QUERY_CYCLES
) (
  // Clock and reset
  input  wire logic                   i_clk,
  input  wire logic                   i_rst_n,
  // APB slave
  input  wire logic                   i_psel,
  input  wire logic                   i_penable,
  input  wire logic                   i_pwrite,
  input  wire logic [`MCS_ADDR_W-1:0] i_paddr,
  input  wire logic [31:0]            i_pwdata,
  output logic      [31:0]            o_prdata,
  output logic                        o_pready,
  output logic                        o_pslverr,
  // Decode results
  input  wire logic                   i_rd_valid,
  input  wire mcs_read_type           i_rd,
  output logic                        o_rd_ready,
  // New-master pin
  input  wire logic                   i_new_master,
  // Result and replacement characters
  output logic                        o_res_valid,
  output mcs_result_type              o_res,
  output logic                        o_chr_valid,
  output mcs_char_type                o_chr,
  input  wire logic                   i_chr_ready
);

  // ------------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------------
  logic [`MCS_CTRL_W-1:0] ctrl;
  logic [15:0]            step;
  logic [VAL_W-1:0]       master;
  logic [3:0]             digits;
  logic [1:0]             load_status;
  logic [6:0]             mlen;
  logic [6:0]             mmlen;
  logic [7:0]             mstr  [`MCS_STR_DEPTH];
  logic [7:0]             mmstr [`MCS_STR_DEPTH];
  mcs_state_type          state;
  logic                   emit_sel;
  logic [5:0]             emit_idx;
  logic                   master_load_status_query_s1;
  logic                   master_load_status_query_s2;
  logic [31:0]            master_load_status_query_cnt;
  logic                   master_load_status_query_done;

  // ------------------------------------------------------------------
  // APB decode
  // ------------------------------------------------------------------
  wire       setup    = i_psel && !i_penable;
  wire       wr       = i_psel && i_penable && i_pwrite;
  wire [3:0] page     = i_paddr[11:8];
  wire [5:0] sidx     = i_paddr[7:2];
  wire       hit_ctrl = (i_paddr == `MCS_OFF_CTRL);
  wire       hit_step = (i_paddr == `MCS_OFF_STEP);
  wire       hit_mst  = (i_paddr == `MCS_OFF_MASTER);
  wire       hit_dig  = (i_paddr == `MCS_OFF_DIGITS);
  wire       hit_cmd  = (i_paddr == `MCS_OFF_CMD);
  wire       hit_lst  = (i_paddr == `MCS_OFF_LOADST);
  wire       hit_mlen = (i_paddr == `MCS_OFF_MLEN);
  wire       hit_mml  = (i_paddr == `MCS_OFF_MMLEN);
  wire       hit_ms   = (page == `MCS_PAGE_MSTR) && (i_paddr[1:0] == 2'b00);
  wire       hit_mms  = (page == `MCS_PAGE_MMSTR) && (i_paddr[1:0] == 2'b00);
  wire       hit_any  = hit_ctrl | hit_step | hit_mst | hit_dig | hit_cmd
                      | hit_lst | hit_mlen | hit_mml | hit_ms | hit_mms;

  // Out-of-range settings are clamped so the counter never sees step 0
  // Upper bound first, so a large value with zero low bits is not taken as 0
  wire [15:0] wr_step = (i_pwdata[31:0] > 32'(`MCS_STEP_MAX)) ? `MCS_STEP_MAX :
                        (i_pwdata[15:0] == 16'h0000) ? `MCS_STEP_MIN :
                        i_pwdata[15:0];
  wire [3:0]  wr_dig  = (i_pwdata[31:0] > 32'(`MCS_DIGITS_MAX)) ? `MCS_DIGITS_MAX :
                        (i_pwdata[3:0] == 4'h0) ? `MCS_DIGITS_MIN :
                        i_pwdata[3:0];
  wire [6:0]  wr_len  = (i_pwdata[31:0] > 32'(`MCS_STR_DEPTH)) ?
                        7'(`MCS_STR_DEPTH) : i_pwdata[6:0];

  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h00000000;
    if (hit_ctrl) rd_mux = 32'(ctrl);
    if (hit_step) rd_mux = 32'(step);
    if (hit_mst)  rd_mux = 32'(master);
    if (hit_dig)  rd_mux = 32'(digits);
    if (hit_lst)  rd_mux = 32'(load_status);
    if (hit_mlen) rd_mux = 32'(mlen);
    if (hit_mml)  rd_mux = 32'(mmlen);
    if (hit_ms)   rd_mux = 32'(mstr[sidx]);
    if (hit_mms)  rd_mux = 32'(mmstr[sidx]);
  end

  // Read data is caught in the setup cycle, so the access phase needs no wait
  assign o_pready = 1'b1;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_prdata  <= 32'h00000000;
      o_pslverr <= 1'b0;
    end else if (setup) begin
      o_prdata  <= i_pwrite ? 32'h00000000 : rd_mux;
      o_pslverr <= !hit_any;
    end
  end

  // ------------------------------------------------------------------
  // Master arithmetic
  // ------------------------------------------------------------------
  function automatic logic [VAL_W:0] pow10(input logic [3:0] d);
    case (d)
      4'h1:    pow10 = (VAL_W+1)'(10);
      4'h2:    pow10 = (VAL_W+1)'(100);
      4'h3:    pow10 = (VAL_W+1)'(1000);
      4'h4:    pow10 = (VAL_W+1)'(10000);
      4'h5:    pow10 = (VAL_W+1)'(100000);
      4'h6:    pow10 = (VAL_W+1)'(1000000);
      4'h7:    pow10 = (VAL_W+1)'(10000000);
      4'h8:    pow10 = (VAL_W+1)'(100000000);
      default: pow10 = (VAL_W+1)'(1000000000);
    endcase
  endfunction

  // Step is reduced first so one correction keeps the result in range
  wire [VAL_W:0] modulus  = pow10(digits);
  wire [VAL_W:0] step_red = (VAL_W+1)'(step) % modulus;
  wire [VAL_W:0] sum      = (VAL_W+1)'(master) + step_red;
  wire [VAL_W:0] inc_val  = (sum >= modulus) ? sum - modulus : sum;
  wire [VAL_W:0] dec_val  = ((VAL_W+1)'(master) >= step_red) ?
                            (VAL_W+1)'(master) - step_red :
                            (VAL_W+1)'(master) + modulus - step_red;
  wire [VAL_W-1:0] seq_val = ctrl[`MCS_CTRL_DIR] ? dec_val[VAL_W-1:0] :
                             inc_val[VAL_W-1:0];

  // ------------------------------------------------------------------
  // Read classification
  // ------------------------------------------------------------------
  wire take      = i_rd_valid && o_rd_ready;
  wire active    = ctrl[`MCS_CTRL_MATCH_EN];
  wire loading   = take && i_rd.good && (load_status != 2'd0);
  wire is_match  = i_rd.good && i_rd.numeric && (i_rd.value == master);
  wire ev_match  = take && active && !loading && is_match;
  wire ev_mism   = take && active && !loading && i_rd.good && !is_match;
  wire ev_nord   = take && active && !i_rd.good;
  wire seq_on    = ctrl[`MCS_CTRL_SEQ_MODE];
  // A mismatch leaves the master alone unless sequencing on mismatch is on
  wire adv_mism  = ctrl[`MCS_CTRL_SEQ_MISM];
  wire advance   = seq_on && (ev_match
                 || (ev_nord && ctrl[`MCS_CTRL_SEQ_NOREAD])
                 || (ev_mism && adv_mism));
  wire rep_match = ev_match && ctrl[`MCS_CTRL_MREPL_EN] && (mlen != 7'h00);
  wire rep_mism  = ev_mism && ctrl[`MCS_CTRL_MMREPL_EN]
                 && (mmlen != 7'h00);

  // ------------------------------------------------------------------
  // New-master pin: synchroniser and 10 ms qualifier
  // ------------------------------------------------------------------
  wire master_load_status_query_gate = active && ctrl[`MCS_CTRL_MASTER_LOAD_STATUS_QUERY_EN];
  wire master_load_status_query_hit  = master_load_status_query_s2 && !master_load_status_query_done && (master_load_status_query_cnt == 32'(MASTER_LOAD_STATUS_QUERY_CYCLES - 1));

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      master_load_status_query_s1 <= 1'b0;
      master_load_status_query_s2 <= 1'b0;
    end else begin
      master_load_status_query_s1 <= i_new_master;
      master_load_status_query_s2 <= master_load_status_query_s1;
    end
  end

  // Count restarts on every drop, so a short pulse never qualifies
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      master_load_status_query_cnt  <= 32'h00000000;
      master_load_status_query_done <= 1'b0;
    end else if (!master_load_status_query_s2) begin
      master_load_status_query_cnt  <= 32'h00000000;
      master_load_status_query_done <= 1'b0;
    end else if (!master_load_status_query_done) begin
      master_load_status_query_cnt  <= master_load_status_query_cnt + 32'h00000001;
      master_load_status_query_done <= master_load_status_query_hit;
    end
  end

  // One master entry: a request arms index 1, the load returns to idle
  wire trig_cmd  = wr && hit_cmd && i_pwdata[`MCS_CMD_TRIGGER];
  wire load_req  = trig_cmd || (master_load_status_query_hit && master_load_status_query_gate);
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      load_status <= 2'd0;
    end else if (load_req) begin
      load_status <= 2'd1;
    end else if (loading) begin
      load_status <= 2'd0;
    end
  end

  // ------------------------------------------------------------------
  // Control and master registers
  // ------------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctrl   <= `MCS_CTRL_RST;
      step   <= `MCS_STEP_RST;
      digits <= `MCS_DIGITS_RST;
      mlen   <= `MCS_MSTR_LEN;
      mmlen  <= `MCS_MMSTR_LEN;
    end else if (wr) begin
      if (hit_ctrl) ctrl   <= i_pwdata[`MCS_CTRL_W-1:0];
      if (hit_step) step   <= wr_step;
      if (hit_dig)  digits <= wr_dig;
      if (hit_mlen) mlen   <= wr_len;
      if (hit_mml)  mmlen  <= wr_len;
    end
  end

  // A software write of the master takes priority over sequencing
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      master    <= '0;
    end else begin
      if (wr && hit_mst) begin
        master <= i_pwdata[VAL_W-1:0];
      end else if (loading) begin
        master <= i_rd.value;
      end else if (advance) begin
        master <= seq_val;
      end
    end
  end

  // ------------------------------------------------------------------
  // Replacement string storage
  // ------------------------------------------------------------------
  for (genvar g = 0; g < `MCS_STR_DEPTH; g++) begin : g_str
    localparam logic [7:0] M_RST  = (g < 5) ?
      8'(`MCS_MSTR_TXT >> ((4 - g) * 8)) : 8'h00;
    localparam logic [7:0] MM_RST = (g < 8) ?
      8'(`MCS_MMSTR_TXT >> ((7 - g) * 8)) : 8'h00;
    always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
        mstr[g]  <= M_RST;
        mmstr[g] <= MM_RST;
      end else if (wr && (sidx == 6'(g))) begin
        if (hit_ms)  mstr[g]  <= i_pwdata[7:0];
        if (hit_mms) mmstr[g] <= i_pwdata[7:0];
      end
    end
  end

  // ------------------------------------------------------------------
  // Result and character output
  // ------------------------------------------------------------------
  wire [6:0] emit_len  = emit_sel ? mmlen : mlen;
  wire       emit_last = (7'(emit_idx) + 7'h01 >= emit_len);
  wire       chr_step  = (state == MCS_ST_EMIT) && i_chr_ready;

  // Decode results stall while a string is being sent
  assign o_rd_ready  = (state == MCS_ST_IDLE);
  assign o_chr_valid = (state == MCS_ST_EMIT);

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state    <= MCS_ST_IDLE;
      emit_sel <= 1'b0;
      emit_idx <= 6'h00;
    end else begin
      case (state)
        MCS_ST_IDLE: begin
          if (rep_match || rep_mism) begin
            state    <= MCS_ST_EMIT;
            emit_sel <= rep_mism;
            emit_idx <= 6'h00;
          end
        end
        MCS_ST_EMIT: begin
          if (chr_step) begin
            emit_idx <= emit_idx + 6'h01;
            if (emit_last) begin
              state <= MCS_ST_IDLE;
            end
          end
        end
        default: begin
          state <= MCS_ST_IDLE;
        end
      endcase
    end
  end

  always_comb begin
    o_chr.code = emit_sel ? mmstr[emit_idx] : mstr[emit_idx];
    o_chr.last = emit_last;
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_res_valid  <= 1'b0;
      o_res        <= '{kind: MCS_RES_NOREAD, replaced: 1'b0};
    end else begin
      o_res_valid  <= loading || ev_match || ev_mism || ev_nord;
      o_res.replaced <= rep_match || rep_mism;
      if (loading) begin
        o_res.kind <= MCS_RES_LOADED;
      end else if (ev_match) begin
        o_res.kind <= MCS_RES_MATCH;
      end else if (ev_mism) begin
        o_res.kind <= MCS_RES_MISMATCH;
      end else begin
        o_res.kind <= MCS_RES_NOREAD;
      end
    end
  end

endmodule

// ==== testbench/mcs_sequencer_properties.sv ====
// Port-level assertions for the matchcode sequencer.
// Assumes one clock domain and the map header for the address width.
`timescale 1ns/1ps
`include "mcs_map.svh"
module mcs_sequencer_properties
  import mcs_pkg::*;
#(
  parameter int VAL_W       = 30,
  parameter int MASTER_LOAD_STATUS_QUERY_CYCLES = `MCS_MASTER_LOAD_STATUS_QUERY_CYCLES
) (
  // Clock, reset and APB
  input wire logic                   i_clk,
  input wire logic                   i_rst_n,
  input wire logic                   i_psel,
  input wire logic                   i_penable,
  input wire logic [`MCS_ADDR_W-1:0] i_paddr,
  input wire logic                   o_pslverr,
  // Results and characters
  input wire logic                   i_rd_valid,
  input wire mcs_read_type           i_rd,
  input wire logic                   o_rd_ready,
  input wire logic                   o_res_valid,
  input wire mcs_result_type         o_res,
  input wire logic                   o_chr_valid,
  input wire mcs_char_type           o_chr,
  input wire logic                   i_chr_ready
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  wire        mapped = i_paddr < 12'h020 || i_paddr[11:8] == 4'h1 || i_paddr[11:8] == 4'h2;
  wire        taken  = i_rd_valid && o_rd_ready;
  wire        chr_go = o_chr_valid && i_chr_ready;
  logic [6:0] n_chr;

  // Characters accepted so far in the current string
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n)
      n_chr <= 7'h00;
    else if (chr_go)
      n_chr <= o_chr.last ? 7'h00 : n_chr + 7'h01;
  end

  property p_err;
    i_psel && i_penable && i_paddr[1:0] == 2'h0 |-> o_pslverr == !mapped;
  endproperty
  a_err: assert property (p_err) else $error("slverr wrong");
  property p_cause; o_res_valid |-> $past(taken); endproperty
  a_cause: assert property (p_cause) else $error("result without read");
  property p_noread;
    o_res_valid |-> (o_res.kind == MCS_RES_NOREAD) == !$past(i_rd.good);
  endproperty
  a_noread: assert property (p_noread) else $error("no-read kind wrong");
  property p_nonnum;
    o_res_valid && $past(i_rd.good && !i_rd.numeric) |-> o_res.kind != MCS_RES_MATCH;
  endproperty
  a_nonnum: assert property (p_nonnum) else $error("text matched");
  property p_repl; o_res_valid |-> o_chr_valid == o_res.replaced; endproperty
  a_repl: assert property (p_repl) else $error("string start wrong");
  property p_hold; o_chr_valid && !i_chr_ready |=> o_chr_valid && $stable(o_chr); endproperty
  a_hold: assert property (p_hold) else $error("char not held");
  property p_busy; o_chr_valid |-> !o_rd_ready; endproperty
  a_busy: assert property (p_busy) else $error("ready while sending");
  property p_last; chr_go && o_chr.last |=> !o_chr_valid && o_rd_ready; endproperty
  a_last: assert property (p_last) else $error("string overran");
  property p_len; o_chr_valid |-> n_chr < 7'h40; endproperty
  a_len: assert property (p_len) else $error("string too long");

  c_match: cover property (o_res_valid && o_res.replaced && o_res.kind == MCS_RES_MATCH);
  c_load: cover property (o_res_valid && o_res.kind == MCS_RES_LOADED);
  c_noread: cover property (o_res_valid && o_res.kind == MCS_RES_NOREAD);
endmodule

bind mcs_sequencer mcs_sequencer_properties #(.VAL_W(VAL_W), .MASTER_LOAD_STATUS_QUERY_CYCLES(MASTER_LOAD_STATUS_QUERY_CYCLES)) u_props (
  .i_clk(i_clk), .i_rst_n(i_rst_n), .i_psel(i_psel), .i_penable(i_penable),
  .i_paddr(i_paddr), .o_pslverr(o_pslverr), .i_rd_valid(i_rd_valid), .i_rd(i_rd),
  .o_rd_ready(o_rd_ready), .o_res_valid(o_res_valid), .o_res(o_res),
  .o_chr_valid(o_chr_valid), .o_chr(o_chr), .i_chr_ready(i_chr_ready));

// ==== testbench/mcs_chr_sink.sv ====
// Character sink after the sequencer; it stalls one beat in four.
// Assumes the character handshake runs on the same clock.
`timescale 1ns/1ps
module mcs_chr_sink
  import mcs_pkg::*;
(
  // Clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_rst_n,
  // Character stream
  input  wire logic         i_chr_valid,
  input  wire mcs_char_type i_chr,
  output logic              o_chr_ready
);
  logic [1:0] beat;
  logic [7:0] got[$];

  // Stalls make the string output prove that it holds each character
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      beat        <= 2'h0;
      o_chr_ready <= 1'b0;
    end else begin
      beat        <= beat + 2'h1;
      o_chr_ready <= beat != 2'h2;
      if (i_chr_valid === 1'b1 && o_chr_ready)
        got.push_back(i_chr.code);
    end
  end
endmodule

// ==== testbench/testbench.sv ====
// Self-checking bench for the matchcode sequencer.
// Assumes the map header, the package, the sink model and the checker.
`timescale 1ns/1ps
`include "mcs_map.svh"
module testbench;
  import mcs_pkg::*;
  logic           i_clk = 1'b0;
  logic           i_rst_n = 1'b0;
  logic           psel = 1'b0;
  logic           pen = 1'b0;
  logic           pwr = 1'b0;
  logic [11:0]    paddr = 12'h000;
  logic [31:0]    pwdata = 32'h0;
  logic           rd_valid = 1'b0;
  logic           master_load_status_query = 1'b0;
  mcs_read_type   rd = '0;
  logic [31:0]    prdata;
  logic           pready, pslverr, rd_ready, res_valid, chr_valid, chr_ready;
  mcs_result_type res;
  mcs_char_type   chr;
  int             num_errors = 0;
  int             checks_done = 0;
  int             cyc = 0;

  mcs_sequencer #(.MASTER_LOAD_STATUS_QUERY_CYCLES(20)) dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_psel(psel),
    .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_rd_valid(rd_valid), .i_rd(rd),
    .o_rd_ready(rd_ready), .i_new_master(master_load_status_query), .o_res_valid(res_valid), .o_res(res),
    .o_chr_valid(chr_valid), .o_chr(chr), .i_chr_ready(chr_ready));
  mcs_chr_sink sink (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_chr_valid(chr_valid),
    .i_chr(chr), .o_chr_ready(chr_ready));

  initial forever #50 i_clk = ~i_clk;

  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic err);
    @(posedge i_clk);
    psel   <= 1'b1;
    pwr    <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge i_clk);
    pen <= 1'b1;
    do @(posedge i_clk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen  <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask

  task automatic chk(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] q;
    logic        e;
    apb(1'b0, a, 32'h0, q, e);
    cmp(q, exp, "register");
  endtask

  // One decode result, then its result code and any replacement string
  task automatic dec(input logic g, input logic [29:0] v, input mcs_kind_type k, input string s,
                     input logic num = 1'b1);
    int n;
    sink.got.delete();
    @(posedge i_clk);
    rd_valid <= 1'b1;
    rd       <= '{good: g, numeric: num, value: v};
    do @(posedge i_clk); while (rd_ready !== 1'b1);
    rd_valid <= 1'b0;
    @(posedge i_clk);
    cmp({31'h0, res_valid}, 32'h1, "result valid");
    cmp({29'h0, res.kind, res.replaced}, {29'h0, k, s.len() != 0}, "result");
    n = 0;
    while (chr_valid !== 1'b0 && n < 500) begin
      @(posedge i_clk);
      n++;
    end
    cmp(sink.got.size(), s.len(), "string length");
    foreach (sink.got[i]) cmp(sink.got[i], s[i], "character");
  endtask

  task automatic pulse(input int n);
    @(posedge i_clk);
    master_load_status_query <= 1'b1;
    repeat (n) @(posedge i_clk);
    master_load_status_query <= 1'b0;
    repeat (5) @(posedge i_clk);
  endtask

  task automatic sc_regs();
    logic [31:0] q;
    logic        e;
    chk(`MCS_OFF_CTRL, 32'h08);
    chk(`MCS_OFF_STEP, 32'h1);
    chk(`MCS_OFF_DIGITS, 32'h3);
    chk(`MCS_OFF_LOADST, 32'h0);
    chk(`MCS_OFF_MLEN, 32'h5);
    chk(`MCS_OFF_MMLEN, 32'h8);
    chk(12'h21C, 32'h48);
    apb(1'b0, 12'h040, 32'h0, q, e);
    cmp({31'h0, e}, 32'h1, "unmapped error");
    wr(`MCS_OFF_STEP, 32'h0);
    chk(`MCS_OFF_STEP, 32'h1);
    wr(`MCS_OFF_STEP, 32'h9C40);
    chk(`MCS_OFF_STEP, 32'h8000);
    wr(`MCS_OFF_STEP, 32'h10000);
    chk(`MCS_OFF_STEP, 32'h8000);
  endtask

  task automatic sc_step();
    wr(`MCS_OFF_CTRL, 32'h0B);
    wr(`MCS_OFF_STEP, 32'h3);
    wr(`MCS_OFF_MASTER, 32'h3);
    dec(1'b1, 30'h1, MCS_RES_MISMATCH, "");
    chk(`MCS_OFF_MASTER, 32'h3);
    dec(1'b1, 30'h2, MCS_RES_MISMATCH, "");
    chk(`MCS_OFF_MASTER, 32'h3);
    dec(1'b1, 30'h3, MCS_RES_MATCH, "");
    chk(`MCS_OFF_MASTER, 32'h6);
    dec(1'b1, 30'h4, MCS_RES_MISMATCH, "");
    chk(`MCS_OFF_MASTER, 32'h6);
    wr(`MCS_OFF_CTRL, 32'h1B);
    dec(1'b1, 30'h1, MCS_RES_MISMATCH, "");
    chk(`MCS_OFF_MASTER, 32'h9);
  endtask

  task automatic sc_wrap();
    wr(`MCS_OFF_CTRL, 32'h0F);
    wr(`MCS_OFF_MASTER, 32'h0);
    dec(1'b1, 30'h0, MCS_RES_MATCH, "");
    chk(`MCS_OFF_MASTER, 32'h3E5);
    wr(`MCS_OFF_CTRL, 32'h0B);
    wr(`MCS_OFF_MASTER, 32'h3E7);
    dec(1'b1, 30'h3E7, MCS_RES_MATCH, "");
    chk(`MCS_OFF_MASTER, 32'h2);
    dec(1'b0, 30'h0, MCS_RES_NOREAD, "");
    chk(`MCS_OFF_MASTER, 32'h5);
    wr(`MCS_OFF_CTRL, 32'h03);
    dec(1'b0, 30'h0, MCS_RES_NOREAD, "");
    chk(`MCS_OFF_MASTER, 32'h5);
    wr(`MCS_OFF_DIGITS, 32'h2);
    chk(`MCS_OFF_DIGITS, 32'h2);
    wr(`MCS_OFF_CTRL, 32'h0B);
    wr(`MCS_OFF_MASTER, 32'h63);
    dec(1'b1, 30'h63, MCS_RES_MATCH, "");
    chk(`MCS_OFF_MASTER, 32'h2);
    wr(`MCS_OFF_DIGITS, 32'h3);
  endtask

  task automatic sc_repl();
    wr(`MCS_OFF_CTRL, 32'hC1);
    wr(`MCS_OFF_MASTER, 32'h7);
    dec(1'b1, 30'h7, MCS_RES_MATCH, "MATCH");
    dec(1'b1, 30'h8, MCS_RES_MISMATCH, "MISMATCH");
    wr(`MCS_OFF_CTRL, 32'h41);
    dec(1'b1, 30'h8, MCS_RES_MISMATCH, "");
    dec(1'b1, 30'h7, MCS_RES_MISMATCH, "", 1'b0);
    wr(`MCS_OFF_CTRL, 32'h01);
    dec(1'b1, 30'h7, MCS_RES_MATCH, "");
    wr(`MCS_OFF_CTRL, 32'hC1);
    wr(`MCS_OFF_MLEN, 32'h1);
    wr(12'h100, 32'h5A);
    dec(1'b1, 30'h7, MCS_RES_MATCH, "Z");
  endtask

  task automatic sc_master_load_status_query();
    wr(`MCS_OFF_CTRL, 32'h01);
    pulse(40);
    chk(`MCS_OFF_LOADST, 32'h0);
    wr(`MCS_OFF_CTRL, 32'h21);
    pulse(10);
    chk(`MCS_OFF_LOADST, 32'h0);
    pulse(40);
    chk(`MCS_OFF_LOADST, 32'h1);
    dec(1'b1, 30'h7B, MCS_RES_LOADED, "");
    chk(`MCS_OFF_MASTER, 32'h7B);
    chk(`MCS_OFF_LOADST, 32'h0);
    wr(`MCS_OFF_CMD, 32'h1);
    chk(`MCS_OFF_LOADST, 32'h1);
    dec(1'b1, 30'h2D, MCS_RES_LOADED, "");
    chk(`MCS_OFF_MASTER, 32'h2D);
    chk(`MCS_OFF_LOADST, 32'h0);
  endtask

  initial begin
    repeat (12) @(posedge i_clk);
    i_rst_n <= 1'b1;
    sc_regs();
    sc_step();
    sc_wrap();
    sc_repl();
    sc_master_load_status_query();
    report_and_stop();
  end
endmodule
